// ===== logic/host_bus_port.v
// local bus host port: arbitration, mastered cycles, slave capture
// assumes all local bus pins synchronous to clk; pads resolve enables
`timescale 1ns/10ps
`include "host_port_consts.vh"

// Function
// - master drives transaction code from the requesting target image field
// - transaction code uses the same cycle timing as the address
// - transfer start driven only while owning bus, low after clock edge
// - address, code, size, direction valid by next edge after start
// - transfer start driven high before release to high impedance
// - slave samples start each edge, captures address on that edge
// - chip selects accepted up to three wait states after start
// - register offset decoded from low twelve address bits only
// - master drives address after edge; slave samples it with start
// - bus busy asserted while owning, driven high before release
// - grant sampled on rising edge, joined with request, and with busy in synchronous mode only
// - optional asynchronous arbitration mode besides synchronous mode
// - master/slave mode strapped at reset from burst pin and size bit 1
// - slave asserts transfer error for a failed transaction
// - master samples transfer error input on rising edge
// - retry is acknowledge plus error together, both directions
// - bus request asserted and released from rising clock edges
// - slave ends cycles with acknowledge, driven high before release
module host_bus_port #(
	parameter ADDR_W = 32,
	parameter TC_W   = 4
) (
	// clock and reset
	input  wire              clk,
	input  wire              sys_rst,
	input  wire              clk_en,
	// internal master request
	input  wire              mreq_valid,
	output wire              mreq_ready,
	input  wire [ADDR_W-1:0] mreq_addr,
	input  wire [TC_W-1:0]   mreq_tc,
	input  wire [1:0]        mreq_size,
	input  wire              mreq_read,
	input  wire              async_arb,
	output reg               mdone_q,
	output reg  [1:0]        mresult_q,
	// internal slave side
	output reg               sreq_q,
	output reg               sreq_reg_q,
	output reg  [ADDR_W-1:0] saddr_q,
	output reg  [`REG_OFFSET_BITS-1:0] sreg_off_q,
	output reg  [TC_W-1:0]   stc_q,
	output reg  [1:0]        ssize_q,
	output reg               sread_q,
	input  wire              sresp_valid,
	input  wire [1:0]        sresp_kind,
	output reg               master_mode_q,
	// transfer start
	input  wire              transfer_start_n_i,
	output reg               transfer_start_n_o,
	output reg               transfer_start_n_oe,
	// address phase pins
	input  wire [ADDR_W-1:0] addr_i,
	output reg  [ADDR_W-1:0] addr_o,
	output reg               addr_oe,
	input  wire [TC_W-1:0]   transaction_code_i,
	output reg  [TC_W-1:0]   transaction_code_o,
	input  wire [1:0]        transfer_size_i,
	output reg  [1:0]        transfer_size_o,
	input  wire              read_write_i,
	output reg               read_write_o,
	// selects and strap
	input  wire              pci_select_n,
	input  wire              register_select_n,
	input  wire              burst_in_progress_n,
	// arbitration
	output reg               bus_request_n,
	input  wire              bus_grant_n,
	input  wire              bus_busy_n_i,
	output reg               bus_busy_n_o,
	output reg               bus_busy_n_oe,
	// termination
	input  wire              transfer_ack_n_i,
	output reg               transfer_ack_n_o,
	output reg               transfer_ack_n_oe,
	input  wire              transfer_error_n_i,
	output reg               transfer_error_n_o,
	output reg               transfer_error_n_oe
);

	// result codes
	localparam RES_OK    = 2'h0;
	localparam RES_ERR   = 2'h1;
	localparam RES_RETRY = 2'h2;
	localparam RES_TMO   = 2'h3;

	// master states
	localparam M_IDLE  = 3'h0;
	localparam M_REQ   = 3'h1;
	localparam M_START = 3'h2;
	localparam M_DATA  = 3'h3;
	localparam M_NEG   = 3'h4;

	// slave states
	localparam S_IDLE = 2'h0;
	localparam S_SEL  = 2'h1;
	localparam S_WAIT = 2'h2;
	localparam S_NEG  = 2'h3;

	// ********************************************************
	// pin synchronisers
	// ********************************************************
	// all pins pass two flops; costs two clocks of latency
	localparam SW = 9;
	wire [SW-1:0] raw = {transfer_start_n_i, pci_select_n,
		register_select_n, burst_in_progress_n, bus_grant_n,
		bus_busy_n_i, transfer_ack_n_i, transfer_error_n_i,
		read_write_i};
	reg  [SW-1:0] s1_q;
	reg  [SW-1:0] s2_q;
	reg  [ADDR_W+TC_W+1:0] b1_q;
	reg  [ADDR_W+TC_W+1:0] b2_q;

	// no reset on these stages: the strap is read through them at the
	// first edge after reset, so they must already hold the pin levels
	always @(posedge clk) begin
		if (clk_en) begin
			s1_q <= raw;
			s2_q <= s1_q;
			b1_q <= {addr_i, transaction_code_i, transfer_size_i};
			b2_q <= b1_q;
		end
	end

	wire ts_n   = s2_q[8];
	wire psel_n = s2_q[7];
	wire rsel_n = s2_q[6];
	wire bip_n  = s2_q[5];
	wire bg_n   = s2_q[4];
	wire bb_n   = s2_q[3];
	wire ta_n   = s2_q[2];
	wire tea_n  = s2_q[1];
	wire rw_s   = s2_q[0];

	// ********************************************************
	// select decode
	// ********************************************************
	// either select claims the cycle; register select names the kind
	wire sel_hit = !psel_n || !rsel_n;
	wire sel_reg = !rsel_n;

	// ********************************************************
	// reset strap
	// ********************************************************
	// read once; later changes of the pins have no effect
	reg strap_done_q;
	always @(posedge clk) begin
		if (sys_rst) begin
			strap_done_q  <= 1'b0;
			master_mode_q <= 1'b0;
		end else if (clk_en && !strap_done_q) begin
			strap_done_q  <= 1'b1;
			master_mode_q <= ({bip_n, b2_q[`SIZE_STRAP_BIT]} ==
				`STRAP_MASTER_CODE);
		end
	end

	// ********************************************************
	// master engine
	// ********************************************************
	reg [2:0] mst_q;
	// a silent slave would hold the bus forever; the timeout frees it
	// the far slave answers through the synchroniser, two clocks late
	reg [7:0] mcnt_q;
	// async mode skips the idle-busy check and reacts on grant alone
	wire bus_free = async_arb ? 1'b1 : bb_n;

	// one mastered cycle at a time, and only when strapped as master
	assign mreq_ready = (mst_q == M_IDLE) && strap_done_q &&
		master_mode_q;

	always @(posedge clk) begin
		if (sys_rst) begin
			mst_q               <= M_IDLE;
			mcnt_q              <= 8'h00;
			bus_request_n       <= 1'b1;
			bus_busy_n_o        <= 1'b1;
			bus_busy_n_oe       <= 1'b0;
			transfer_start_n_o  <= 1'b1;
			transfer_start_n_oe <= 1'b0;
			addr_o              <= {ADDR_W{1'b0}};
			addr_oe             <= 1'b0;
			transaction_code_o  <= {TC_W{1'b0}};
			transfer_size_o     <= 2'h0;
			read_write_o        <= 1'b1;
			mdone_q             <= 1'b0;
			mresult_q           <= RES_OK;
		end else if (clk_en) begin
			mdone_q <= 1'b0;
			case (mst_q)
			M_IDLE: begin
				if (mreq_valid && mreq_ready) begin
					bus_request_n <= 1'b0;
					mst_q         <= M_REQ;
				end
			end
			M_REQ: begin
				if (!bg_n && bus_free) begin
					bus_request_n       <= 1'b1;
					bus_busy_n_o        <= 1'b0;
					bus_busy_n_oe       <= 1'b1;
					transfer_start_n_o  <= 1'b0;
					transfer_start_n_oe <= 1'b1;
					addr_o              <= mreq_addr;
					transaction_code_o  <= mreq_tc;
					transfer_size_o     <= mreq_size;
					read_write_o        <= mreq_read;
					addr_oe             <= 1'b1;
					mst_q               <= M_START;
				end
			end
			M_START: begin
				// start low for exactly one clock, then driven high
				transfer_start_n_o <= 1'b1;
				mcnt_q             <= 8'h00;
				mst_q              <= M_DATA;
			end
			M_DATA: begin
				mcnt_q <= mcnt_q + 8'h01;
				if (!ta_n || !tea_n || mcnt_q == `MASTER_TIMEOUT) begin
					// retry outranks error when both lines come low
					if (!ta_n && !tea_n)
						mresult_q <= RES_RETRY;
					else if (!tea_n)
						mresult_q <= RES_ERR;
					else if (!ta_n)
						mresult_q <= RES_OK;
					else
						mresult_q <= RES_TMO;
					bus_busy_n_o        <= 1'b1;
					transfer_start_n_oe <= 1'b0;
					addr_oe             <= 1'b0;
					mst_q               <= M_NEG;
				end
			end
			M_NEG: begin
				bus_busy_n_oe <= 1'b0;
				mdone_q       <= 1'b1;
				mst_q         <= M_IDLE;
			end
			default: mst_q <= M_IDLE;
			endcase
		end
	end

	// ********************************************************
	// slave engine
	// ********************************************************
	reg [1:0] sst_q;
	reg [1:0] wcnt_q;
	// our own start comes back through the synchroniser; only a
	// foreign start seen while idle or requesting is captured
	wire mine = (mst_q == M_IDLE) || (mst_q == M_REQ);

	always @(posedge clk) begin
		if (sys_rst) begin
			sst_q               <= S_IDLE;
			wcnt_q              <= 2'h0;
			sreq_q              <= 1'b0;
			sreq_reg_q          <= 1'b0;
			saddr_q             <= {ADDR_W{1'b0}};
			sreg_off_q          <= {`REG_OFFSET_BITS{1'b0}};
			stc_q               <= {TC_W{1'b0}};
			ssize_q             <= 2'h0;
			sread_q             <= 1'b1;
			transfer_ack_n_o    <= 1'b1;
			transfer_ack_n_oe   <= 1'b0;
			transfer_error_n_o  <= 1'b1;
			transfer_error_n_oe <= 1'b0;
		end else if (clk_en) begin
			sreq_q <= 1'b0;
			case (sst_q)
			S_IDLE: begin
				if (!ts_n && mine) begin
					// capture on the edge that sees start low
					saddr_q <= b2_q[ADDR_W+TC_W+1:TC_W+2];
					sreg_off_q <= b2_q[TC_W+2+`REG_OFFSET_BITS-1:TC_W+2];
					// upper address bits never reach the decode
					stc_q   <= b2_q[TC_W+1:2];
					ssize_q <= b2_q[1:0];
					sread_q <= rw_s;
					// the start edge itself is the first select sample
					wcnt_q  <= 2'h1;
					if (sel_hit) begin
						sreq_q     <= 1'b1;
						sreq_reg_q <= sel_reg;
						sst_q      <= S_WAIT;
					end else begin
						sst_q <= S_SEL;
					end
				end
			end
			S_SEL: begin
				if (sel_hit) begin
					sreq_q     <= 1'b1;
					sreq_reg_q <= sel_reg;
					sst_q      <= S_WAIT;
				end else if (wcnt_q == `SEL_WAIT_MAX) begin
					sst_q <= S_IDLE; // not addressed to us
				end else begin
					wcnt_q <= wcnt_q + 2'h1;
				end
			end
			S_WAIT: begin
				// every answer drives both lines so neither floats
				if (sresp_valid) begin
					transfer_ack_n_oe   <= 1'b1;
					transfer_error_n_oe <= 1'b1;
					transfer_ack_n_o    <= (sresp_kind == RES_ERR);
					transfer_error_n_o  <= (sresp_kind == RES_OK);
					if (sresp_kind == RES_RETRY) begin
						transfer_ack_n_o   <= 1'b0;
						transfer_error_n_o <= 1'b0;
					end
					sst_q <= S_NEG;
				end
			end
			S_NEG: begin
				// one clock driven high before release, never left low
				if (!transfer_ack_n_o || !transfer_error_n_o) begin
					transfer_ack_n_o   <= 1'b1;
					transfer_error_n_o <= 1'b1;
				end else begin
					transfer_ack_n_oe   <= 1'b0;
					transfer_error_n_oe <= 1'b0;
					sst_q               <= S_IDLE;
				end
			end
			default: sst_q <= S_IDLE;
			endcase
		end
	end

endmodule

// ===== logic/host_port_consts.vh
// constants for the local bus host port block
// assumes inclusion by the single design file of the block
`ifndef HOST_PORT_CONSTS_VH
`define HOST_PORT_CONSTS_VH

// register offset decode width
`define REG_OFFSET_BITS      12
// slave wait for delayed chip selects
`define SEL_WAIT_MAX         3
// master bus cycle timeout in clocks
`define MASTER_TIMEOUT       8'hFF
// strap decode: {burst_in_progress level, size bit 1}
`define STRAP_MASTER_CODE    2'h1
`define SIZE_STRAP_BIT       1

`endif

// ===== testbench/host_bus_port_checker.sv
// checker: pin timing relations of the host port
// assumes bind onto host_bus_port, one clock domain
`timescale 1ns/10ps
`include "host_port_consts.vh"
module host_bus_port_checker #(
	parameter ADDR_W = 32,
	parameter TC_W   = 4
) (
	input wire				clk,
	input wire				sys_rst,
	input wire				sresp_valid,
	input wire [1:0]			sresp_kind,
	input wire				sreq_q,
	input wire [ADDR_W-1:0]			saddr_q,
	input wire [`REG_OFFSET_BITS-1:0]	sreg_off_q,
	input wire				bus_request_n,
	input wire				bus_grant_n,
	input wire				transfer_start_n_o,
	input wire				transfer_start_n_oe,
	input wire [ADDR_W-1:0]			addr_o,
	input wire				addr_oe,
	input wire [TC_W-1:0]			transaction_code_o,
	input wire				bus_busy_n_o,
	input wire				bus_busy_n_oe,
	input wire				transfer_ack_n_o,
	input wire				transfer_ack_n_oe,
	input wire				transfer_error_n_o
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_start_owns_bus: assert property (
		transfer_start_n_oe |-> addr_oe && bus_busy_n_oe && !bus_busy_n_o)
		else $error("start driven without owning the bus");
	a_start_one_low: assert property (
		$rose(transfer_start_n_oe) |-> !transfer_start_n_o ##1 transfer_start_n_o)
		else $error("start not low for exactly one cycle");
	a_start_rescind: assert property (
		$fell(transfer_start_n_oe) |-> $past(transfer_start_n_o))
		else $error("start released while low");
	a_addr_code_steady: assert property (
		addr_oe && $past(addr_oe) |-> $stable(addr_o) && $stable(transaction_code_o))
		else $error("address or code moved while driven");
	a_busy_rescind: assert property (
		$fell(bus_busy_n_oe) |-> $past(bus_busy_n_o))
		else $error("busy released while low");
	a_grant_first: assert property (
		$rose(transfer_start_n_oe) |-> !$past(bus_grant_n, 2) && bus_request_n)
		else $error("ownership taken without grant");
	a_retry_both: assert property (
		sresp_valid && sresp_kind == 2'h2 |=>
		!transfer_ack_n_o && !transfer_error_n_o && transfer_ack_n_oe)
		else $error("retry not shown on both lines");
	a_ack_rescind: assert property (
		$fell(transfer_ack_n_oe) |-> $past(transfer_ack_n_o))
		else $error("acknowledge released while low");
	a_reg_offset: assert property (
		$rose(sreq_q) |-> sreg_off_q == saddr_q[`REG_OFFSET_BITS-1:0])
		else $error("register offset not low address bits");
	c_master: cover property ($rose(transfer_start_n_oe));
	c_slave: cover property ($rose(sreq_q));
	c_error: cover property (sresp_valid && sresp_kind == 2'h1);
endmodule
bind host_bus_port host_bus_port_checker #(.ADDR_W(ADDR_W), .TC_W(TC_W)) u_chk (
	.clk(clk), .sys_rst(sys_rst), .sresp_valid(sresp_valid),
	.sresp_kind(sresp_kind), .sreq_q(sreq_q), .saddr_q(saddr_q),
	.sreg_off_q(sreg_off_q), .bus_request_n(bus_request_n),
	.bus_grant_n(bus_grant_n), .transfer_start_n_o(transfer_start_n_o),
	.transfer_start_n_oe(transfer_start_n_oe), .addr_o(addr_o),
	.addr_oe(addr_oe), .transaction_code_o(transaction_code_o),
	.bus_busy_n_o(bus_busy_n_o), .bus_busy_n_oe(bus_busy_n_oe),
	.transfer_ack_n_o(transfer_ack_n_o), .transfer_ack_n_oe(transfer_ack_n_oe),
	.transfer_error_n_o(transfer_error_n_o));

// ===== testbench/host_partner.sv
// partner: arbiter and addressed slave for cycles the port masters
// assumes released lines pulled up; wait 8'hFF never answers
`timescale 1ns/10ps
module host_partner (
	input  wire		clk,
	input  wire [1:0]	resp_kind,
	input  wire [7:0]	resp_wait,
	input  wire		bus_request_n,
	input  wire		transfer_start_n,
	output reg		bus_grant_n = 1'b1,
	output reg		ack_n = 1'b1,
	output reg		err_n = 1'b1
);
	reg [8:0]	cnt_q = 9'h1FF;
	// count restarts on each start, so a stale wait cannot fire
	always @(negedge clk) begin
		bus_grant_n <= bus_request_n;
		ack_n <= 1'b1;
		err_n <= 1'b1;
		if (!transfer_start_n)
			cnt_q <= {1'b0, resp_wait};
		else if (cnt_q == 9'h0) begin
			cnt_q <= 9'h1FF;
			ack_n <= resp_kind == 2'h1;
			err_n <= resp_kind == 2'h0;
		end else if (cnt_q != 9'h1FF && resp_wait != 8'hFF)
			cnt_q <= cnt_q - 9'h1;
	end
endmodule

// ===== testbench/host_bus_port_tb.sv
// bench: strap, mastered cycles with each ending, slave captures
// assumes host_partner answers the cycles the port masters
`timescale 1ns/10ps
`include "host_port_consts.vh"
module host_bus_port_tb;
	reg		clk = 1'b0, sys_rst = 1'b1, mv = 1'b0, arb = 1'b0, sv = 1'b0;
	reg		ts_n = 1'b1, rw = 1'b0, psel_n = 1'b1, rsel_n = 1'b1, burst_n = 1'b1;
	reg [1:0]	sk = 2'h0, sz = 2'h0, pk = 2'h0;
	reg [3:0]	tc = 4'h0;
	reg [7:0]	pw = 8'h00;
	reg [31:0]	a = 32'h0;
	reg		bb_ext = 1'b1;
	wire		rdy, done, sreq, sreg, mm, ts_o, ts_oe, a_oe, rw_o, br_n, srd;
	wire		bg_n, bb_o, bb_oe, ta_o, ta_oe, te_o, te_oe, p_ta, p_te;
	wire [1:0]	res, sz_o, ssz;
	wire [3:0]	stc, tc_o;
	wire [`REG_OFFSET_BITS-1:0]	soff;
	wire [31:0]	sa, a_o;
	wire		ta_w = ta_oe ? ta_o : p_ta;
	wire		te_w = te_oe ? te_o : p_te;
	integer		err_count = 0, cmp_count = 0, i, j;
	always #25 clk = ~clk;
	host_bus_port u_host_bus_port (.clk(clk), .sys_rst(sys_rst), .clk_en(1'b1),
		.mreq_valid(mv), .mreq_ready(rdy), .mreq_addr(a), .mreq_tc(tc),
		.mreq_size(sz), .mreq_read(rw), .async_arb(arb), .mdone_q(done),
		.mresult_q(res), .sreq_q(sreq), .sreq_reg_q(sreg), .saddr_q(sa),
		.sreg_off_q(soff), .stc_q(stc), .ssize_q(ssz), .sread_q(srd),
		.sresp_valid(sv), .sresp_kind(sk), .master_mode_q(mm),
		.transfer_start_n_i(ts_oe ? ts_o : ts_n), .transfer_start_n_o(ts_o),
		.transfer_start_n_oe(ts_oe), .addr_i(a_oe ? a_o : a), .addr_o(a_o),
		.addr_oe(a_oe), .transaction_code_i(a_oe ? tc_o : tc),
		.transaction_code_o(tc_o), .transfer_size_i(a_oe ? sz_o : sz),
		.transfer_size_o(sz_o), .read_write_i(a_oe ? rw_o : rw),
		.read_write_o(rw_o), .pci_select_n(psel_n), .register_select_n(rsel_n),
		.burst_in_progress_n(burst_n), .bus_request_n(br_n), .bus_grant_n(bg_n),
		.bus_busy_n_i(bb_oe ? bb_o : bb_ext), .bus_busy_n_o(bb_o),
		.bus_busy_n_oe(bb_oe), .transfer_ack_n_i(ta_w), .transfer_ack_n_o(ta_o),
		.transfer_ack_n_oe(ta_oe), .transfer_error_n_i(te_w),
		.transfer_error_n_o(te_o), .transfer_error_n_oe(te_oe));
	host_partner u_host_partner (.clk(clk), .resp_kind(pk), .resp_wait(pw),
		.bus_request_n(br_n), .transfer_start_n(ts_oe ? ts_o : 1'b1),
		.bus_grant_n(bg_n), .ack_n(p_ta), .err_n(p_te));
	task chk(input [63:0] g, input [63:0] e);
		begin
			cmp_count = cmp_count + 1;
			if (g !== e) begin
				err_count = err_count + 1;
				$display("unexpected at %0t: got %h exp %h", $time, g, e);
			end
		end
	endtask
	task stop_test;
		begin
			$display("compares %0d mismatches %0d", cmp_count, err_count);
			if (err_count == 0 && cmp_count > 0)
				$display("TEST PASSED");
			else
				$display("TEST FAILED");
			$finish;
		end
	endtask
	task do_reset(input [1:0] s);
		begin
			sys_rst = 1'b1;
			{burst_n, sz} = {s, 1'b0};
			repeat (20) @(negedge clk);
			sys_rst = 1'b0;
			repeat (3) @(negedge clk);
			chk({mm, rdy}, {s == 2'h1, s == 2'h1});
			$display("strap %0d done", s);
		end
	endtask
	task t_master(input [1:0] k);
		begin
			pk = k;
			arb = k[0];
			// in async runs a foreign owner holds busy low: only async mode may go
			bb_ext = ~k[0];
			a = {28'hA5C3E71, k, 2'h2};
			tc = {k, ~k};
			sz = k;
			rw = k[1];
			pw = (k == 2'h3) ? 8'hFF : {5'h0, k, 1'b0};
			chk(rdy, 1'b1);
			mv = 1'b1;
			@(negedge clk);
			mv = 1'b0;
			for (i = 0; i < 40 && (ts_oe & ~ts_o) !== 1'b1; i = i + 1)
				@(negedge clk);
			chk({ts_oe, a_o, tc_o, sz_o, rw_o}, {1'b1, a, tc, sz, rw});
			for (i = 0; i < 300 && done !== 1'b1; i = i + 1)
				@(negedge clk);
			chk({done, res, a_oe}, {1'b1, k, 1'b0});
			if (done !== 1'b1)
				stop_test;
			else
				$display("master ending %0d done", k);
		end
	endtask
	task t_slave(input [2:0] w, input r, input [1:0] k);
		begin
			{a, tc, sk, ts_n} = {32'hFEDCBA5C, 4'h9, k, 1'b0};
			{sz, rw} = {k, ~r};
			for (i = 0; i < 9 && sreq !== 1'b1; i = i + 1) begin
				if (i == w)
					{psel_n, rsel_n} = {r, ~r};
				@(negedge clk);
				ts_n = 1'b1;
			end
			if (w == 3'h4)
				chk(sreq, 1'b0);
			else begin
				chk({sreq, sreg, sa, soff, stc, ssz, srd},
					{1'b1, r, a, 12'hA5C, tc, k, ~r});
				sv = 1'b1;
				@(negedge clk);
				sv = 1'b0;
				chk({ta_w, te_w}, {k == 2'h1, k == 2'h0});
				repeat (3) @(negedge clk);
				chk({ta_oe, te_oe}, 2'h0);
			end
			{psel_n, rsel_n} = 2'h3;
			repeat (3) @(negedge clk);
			$display("slave wait %0d done", w);
		end
	endtask
	initial begin
		do_reset(2'h1);
		for (j = 0; j < 4; j = j + 1)
			t_master(j[1:0]);
		t_slave(3'h0, 1'b1, 2'h0);
		t_slave(3'h3, 1'b0, 2'h1);
		t_slave(3'h2, 1'b1, 2'h2);
		t_slave(3'h4, 1'b0, 2'h0);
		do_reset(2'h2);
		t_slave(3'h1, 1'b1, 2'h0);
		stop_test;
	end
endmodule
